// File: rtl/aod_axis_offset_and_activity_detect.sv
// Purpose: offset trim of three axis results and motion run detection
// Assumes: results arrive with a one-cycle sample_valid strobe
// Notes: trimmed sum wraps in 20 bits; read data follows one cycle late
// How it works
// - x trim, high byte at 0x1E, low at 0x1F, added after processing.
// - y trim, high byte at 0x20, low at 0x21, added after processing.
// - z trim, high byte at 0x22, low at 0x23, added after processing.
// - trim bits 15..0 weigh as result bits 19..4, with bits 3..0 filled with zero.
// - axis joins detection only if its select bit set; bits 7..3 read 0.
// - limit is 16-bit unsigned, high byte 0x25, low byte 0x26.
// - limit compared against magnitude bits 18..3 of each enabled axis.
// - an event needs magnitude strictly greater than the limit.
// - motion declared after run-length consecutive events; resets to one.
// - axis results are 20-bit twos complement values.
// - motion event drives pin a if map bit 3, pin b if map bit 7.
`timescale 1ns/1ps
`default_nettype none
module aod_axis_offset_and_activity_detect
    import aod_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire aod_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sample_valid,
    input wire aod_axes_s raw_result,
    output aod_axes_s trimmed_result,
    output logic trimmed_valid,
    output logic motion_event,
    output logic irq_pin_a,
    output logic irq_pin_b
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [TRIM_W-1:0] trim [AXES];
    logic [2:0] motion_axis_select;
    logic [15:0] motion_limit;
    logic [CNT_W-1:0] motion_run_length;
    logic [7:0] irq_map;
    logic [CNT_W-1:0] run_count;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = reg_req.wr && (a == ofs);
    endfunction

    // halves land on their own write; no shadow, so a host
    // updating both bytes sees a mixed trim for one sample
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < AXES; i++) begin
                trim[i] <= {RST_TRIM, RST_TRIM};
            end
        end else begin
            if (hit(reg_req.addr, OFS_X_TRIM_HIGH)) begin
                trim[0][15:8] <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_X_TRIM_LOW)) begin
                trim[0][7:0] <= reg_req.wdata;
            end

            if (hit(reg_req.addr, OFS_Y_TRIM_HIGH)) begin
                trim[1][15:8] <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_Y_TRIM_LOW)) begin
                trim[1][7:0] <= reg_req.wdata;
            end

            if (hit(reg_req.addr, OFS_Z_TRIM_HIGH)) begin
                trim[2][15:8] <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_Z_TRIM_LOW)) begin
                trim[2][7:0] <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            motion_axis_select <= RST_AXIS_SELECT;
            motion_limit <= RST_LIMIT;
            motion_run_length <= RST_RUN_LENGTH;
            irq_map <= RST_IRQ_MAP;
        end else begin
            if (hit(reg_req.addr, OFS_MOTION_AXIS_SELECT)) begin
                motion_axis_select <= reg_req.wdata[2:0];
            end
            if (hit(reg_req.addr, OFS_MOTION_LIMIT_HIGH)) begin
                motion_limit[15:8] <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_MOTION_LIMIT_LOW)) begin
                motion_limit[7:0] <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_MOTION_RUN_LENGTH)) begin
                motion_run_length <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_IRQ_MAP)) begin
                irq_map <= reg_req.wdata;
            end
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [7:0] next_rdata;
    always_comb begin
        case (reg_req.addr)
            OFS_X_TRIM_HIGH: next_rdata = trim[0][15:8];
            OFS_X_TRIM_LOW: next_rdata = trim[0][7:0];
            OFS_Y_TRIM_HIGH: next_rdata = trim[1][15:8];
            OFS_Y_TRIM_LOW: next_rdata = trim[1][7:0];
            OFS_Z_TRIM_HIGH: next_rdata = trim[2][15:8];
            OFS_Z_TRIM_LOW: next_rdata = trim[2][7:0];
            OFS_MOTION_AXIS_SELECT: next_rdata = {5'h00, motion_axis_select};
            OFS_MOTION_LIMIT_HIGH: next_rdata = motion_limit[15:8];
            OFS_MOTION_LIMIT_LOW: next_rdata = motion_limit[7:0];
            OFS_MOTION_RUN_LENGTH: next_rdata = motion_run_length;
            OFS_IRQ_MAP: next_rdata = irq_map;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            // a write in the same cycle shows on the next read only
            reg_rdata <= reg_req.rd ? next_rdata : 8'h00;
            reg_rvalid <= reg_req.rd;
        end
    end

    // ************************************************************
    // trim and compare
    // ************************************************************
    logic [RES_W-1:0] raw [AXES];
    logic [RES_W-1:0] sum [AXES];
    logic [AXES-1:0] above;
    assign raw[0] = raw_result.x;
    assign raw[1] = raw_result.y;
    assign raw[2] = raw_result.z;

    // -2^19 has no positive twin and stays 0x80000
    function automatic logic [RES_W-1:0] magnitude(input logic [RES_W-1:0] v);
        magnitude = v[RES_W-1] ? RES_W'(~v + 1'b1) : v;
    endfunction

    for (genvar g = 0; g < AXES; g++) begin : g_axis
        logic [RES_W-1:0] mag;
        // align trim to bits 19..4, zero-fill bits 3..0
        assign sum[g] = raw[g] + {trim[g], {TRIM_SHIFT{1'b0}}};
        assign mag = magnitude(sum[g]);
        // strict compare on bits 18..3
        // full-scale negative gives bit 19 set; treat as above any limit
        assign above[g] = motion_axis_select[g] && (mag[RES_W-1] ||
            (mag[LIMIT_MSB:LIMIT_LSB] > motion_limit));
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trimmed_result <= '0;
            trimmed_valid <= 1'b0;
        end else begin
            trimmed_valid <= sample_valid;
            if (sample_valid) begin
                trimmed_result <= {sum[2], sum[1], sum[0]};
            end
        end
    end

    // ************************************************************
    // run counter and event routing
    // ************************************************************
    logic [CNT_W-1:0] next_count;
    logic next_event;
    logic fire;
    always_comb begin
        next_count = '0;
        if (|above) begin
            // saturate so a long run never wraps below the length
            if (&run_count) begin
                next_count = run_count;
            end else begin
                next_count = CNT_W'(run_count + 1'b1);
            end
        end
        next_event = (|above) && (next_count >= motion_run_length);
    end
    assign fire = sample_valid && next_event;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_count <= '0;
            motion_event <= 1'b0;
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end else begin
            motion_event <= fire;
            irq_pin_a <= fire && irq_map[BIT_ROUTE_PIN_A];
            irq_pin_b <= fire && irq_map[BIT_ROUTE_PIN_B];
            if (sample_valid) begin
                run_count <= next_count;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/aod_pkg.sv
// Purpose: shared constants and types for the axis trim and motion detector
// Assumes: byte-wide register port, one clock domain
// Notes: offsets are byte addresses of the register port
`default_nettype none
package aod_pkg;
    localparam int RES_W = 20;
    localparam int TRIM_W = 16;
    localparam int TRIM_SHIFT = 4;
    localparam int LIMIT_LSB = 3;
    localparam int LIMIT_MSB = 18;
    localparam int CNT_W = 8;
    localparam int AXES = 3;

    localparam logic [7:0] OFS_X_TRIM_HIGH = 8'h1E;
    localparam logic [7:0] OFS_X_TRIM_LOW = 8'h1F;
    localparam logic [7:0] OFS_Y_TRIM_HIGH = 8'h20;
    localparam logic [7:0] OFS_Y_TRIM_LOW = 8'h21;
    localparam logic [7:0] OFS_Z_TRIM_HIGH = 8'h22;
    localparam logic [7:0] OFS_Z_TRIM_LOW = 8'h23;
    localparam logic [7:0] OFS_MOTION_AXIS_SELECT = 8'h24;
    localparam logic [7:0] OFS_MOTION_LIMIT_HIGH = 8'h25;
    localparam logic [7:0] OFS_MOTION_LIMIT_LOW = 8'h26;
    localparam logic [7:0] OFS_MOTION_RUN_LENGTH = 8'h27;
    localparam logic [7:0] OFS_IRQ_MAP = 8'h2A;

    localparam int BIT_USE_X = 0;
    localparam int BIT_USE_Y = 1;
    localparam int BIT_USE_Z = 2;
    localparam int BIT_ROUTE_PIN_A = 3;
    localparam int BIT_ROUTE_PIN_B = 7;

    localparam logic [7:0] RST_TRIM = 8'h00;
    localparam logic [2:0] RST_AXIS_SELECT = 3'h0;
    localparam logic [15:0] RST_LIMIT = 16'h0000;
    localparam logic [7:0] RST_RUN_LENGTH = 8'h01;
    localparam logic [7:0] RST_IRQ_MAP = 8'h00;

    typedef struct packed {
        logic [RES_W-1:0] z;
        logic [RES_W-1:0] y;
        logic [RES_W-1:0] x;
    } aod_axes_s;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } aod_reg_req_s;
endpackage
`default_nettype wire

// File: verification/aod_checker.sv
// Purpose: port assertions for the trim and motion block
// Assumes: one clock, async active-low reset
// Notes: bound below to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module aod_checker
    import aod_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire aod_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic sample_valid,
    input wire aod_axes_s trimmed_result,
    input wire logic trimmed_valid,
    input wire logic motion_event,
    input wire logic irq_pin_a,
    input wire logic irq_pin_b
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered");
    a_answer_cause: assert property (
        reg_rvalid |-> $past(reg_req.rd))
        else $error("answer without read");
    a_select_reserved: assert property (reg_req.rd
        && reg_req.addr == OFS_MOTION_AXIS_SELECT |=> reg_rdata[7:3] == 5'h00)
        else $error("select upper bits not zero");
    a_unmapped_zero: assert property (reg_req.rd
        && reg_req.addr == 8'h28 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_sample_answer: assert property (
        sample_valid |=> trimmed_valid)
        else $error("sample not answered");
    a_motion_cause: assert property (
        motion_event |-> $past(sample_valid))
        else $error("motion without sample");
    a_pin_a_cause: assert property (irq_pin_a |-> motion_event)
        else $error("pin a without motion");
    a_pin_b_cause: assert property (irq_pin_b |-> motion_event)
        else $error("pin b without motion");
    a_trim_holds: assert property (
        !trimmed_valid |-> $stable(trimmed_result))
        else $error("result moved between samples");
    c_motion: cover property (motion_event);
    c_pin_b: cover property (irq_pin_b);
    c_reads: cover property (reg_rvalid ##2 reg_rvalid);
endmodule
bind aod_axis_offset_and_activity_detect aod_checker i_aod_checker (.ref_clk,
    .arst_n, .reg_req, .reg_rdata, .reg_rvalid, .sample_valid, .trimmed_result,
    .trimmed_valid, .motion_event, .irq_pin_a, .irq_pin_b);
`default_nettype wire

// File: verification/aod_host.sv
// Purpose: host model issuing register writes and reads
// Assumes: strobes taken on the rising edge, answer one cycle on
// Notes: released lines show inverted values, never the last ones
`timescale 1ns/1ps
`default_nettype none
module aod_host
    import aod_pkg::*;
(
    input wire logic ref_clk,
    output var aod_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '{addr: 8'hFF, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk);
        reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5A};
        @(negedge ref_clk);
        reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
        // a missing answer must not pass as data
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: register, trim and motion tests of the block
// Assumes: inputs change on the falling edge
// Notes: expectations come from the register map and trim arithmetic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aod_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sample_valid = 1'b0;
    aod_axes_s raw_result = '0;
    aod_reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid, trimmed_valid, motion_event, irq_pin_a, irq_pin_b;
    aod_axes_s trimmed_result;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rv;
    logic [19:0] x_in;
    logic [2:0] e_in;
    logic [15:0] cfg [12] = '{16'h1EFF, 16'h1FFF, 16'h207F, 16'h21FF,
        16'h2200, 16'h2310, 16'h1E00, 16'h1F00, 16'h2501, 16'h2600,
        16'h2702, 16'h2A88};
    logic [22:0] det [6] = '{{20'h00800, 3'd0}, {20'h00808, 3'd0},
        {20'hFF7F8, 3'd7}, {20'h00000, 3'd0}, {20'h00808, 3'd0},
        {20'h00808, 3'd7}};
    always #5 ref_clk = ~ref_clk;
    aod_axis_offset_and_activity_detect i_aod_axis_offset_and_activity_detect (
        .ref_clk, .arst_n, .reg_req, .reg_rdata, .reg_rvalid, .sample_valid,
        .raw_result, .trimmed_result, .trimmed_valid, .motion_event,
        .irq_pin_a, .irq_pin_b);
    aod_host i_aod_host (.ref_clk, .reg_req, .reg_rdata, .reg_rvalid);
    task automatic chk(input string n, input logic [59:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // trim shifted left four, wraps in 20 bits
    function automatic logic [19:0] trim(input logic [19:0] r, logic [15:0] t);
        return r + {t, 4'h0};
    endfunction
    function automatic logic [7:0] regval(input logic [7:0] a, d);
        if (a == 8'h24) return d & 8'h07;
        if ((a >= 8'h1E && a <= 8'h27) || a == 8'h2A) return d;
        return 8'h00;
    endfunction
    task automatic samp(input logic [19:0] x, y, z, input logic [2:0] e);
        @(negedge ref_clk);
        raw_result = '{z: z, y: y, x: x};
        sample_valid = 1'b1;
        @(negedge ref_clk);
        sample_valid = 1'b0;
        raw_result = ~raw_result;
        chk("tvalid", trimmed_valid, 1'b1);
        chk("motion", motion_event, e[2]);
        chk("pins", {irq_pin_a, irq_pin_b}, e[1:0]);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        for (int a = 8'h1D; a <= 8'h2A; a++) begin
            i_aod_host.rd(8'(a), rv);
            chk("reset", rv, (a == 8'h27) ? 8'h01 : 8'h00);
        end
        $display("reset values done");
        for (int a = 8'h1D; a <= 8'h2A; a++) begin
            i_aod_host.wr(8'(a), 8'(a ^ 8'hA5));
        end
        for (int a = 8'h1D; a <= 8'h2A; a++) begin
            i_aod_host.rd(8'(a), rv);
            chk("reg", rv, regval(8'(a), 8'(a ^ 8'hA5)));
        end
        $display("register access done");
        for (int i = 0; i < 6; i++) i_aod_host.wr(cfg[i][15:8], cfg[i][7:0]);
        samp(20'h00020, 20'h80000, 20'hFFFF0, 3'd0);
        chk("trimmed", trimmed_result, {
            trim(20'hFFFF0, 16'h0010), trim(20'h80000, 16'h7FFF),
            trim(20'h00020, 16'hFFFF)});
        $display("trim done");
        for (int i = 6; i < 12; i++) i_aod_host.wr(cfg[i][15:8], cfg[i][7:0]);
        foreach (det[i]) begin
            // y stays far above the limit but is not selected
            {x_in, e_in} = det[i];
            samp(x_in, 20'h40000, 20'h0, e_in);
        end
        i_aod_host.wr(8'h2A, 8'h08);
        samp(20'h00808, 20'h40000, 20'h0, 3'b110);
        $display("motion done");
        // y and z selected, run length zero, pin b only
        i_aod_host.wr(8'h24, 8'h06);
        i_aod_host.wr(8'h27, 8'h00);
        i_aod_host.wr(8'h2A, 8'h80);
        i_aod_host.wr(8'h20, 8'h00);
        i_aod_host.wr(8'h21, 8'h00);
        samp(20'h40000, 20'h0, 20'h0, 3'd0);
        // full-scale negative y counts above any limit
        samp(20'h0, 20'h80000, 20'h0, 3'b101);
        samp(20'h0, 20'h0, 20'h00708, 3'b101);
        $display("axis select done");
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        chk("rst result", trimmed_result, 60'h0);
        chk("rst motion", {motion_event, irq_pin_a, irq_pin_b}, 3'd0);
        i_aod_host.rd(8'h27, rv);
        chk("rst length", rv, 8'h01);
        i_aod_host.rd(8'h24, rv);
        chk("rst select", rv, 8'h00);
        i_aod_host.rd(8'h20, rv);
        chk("rst trim", rv, 8'h00);
        $display("mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
